// ### design/tsi_irq_block.v
// Two-source interrupt controller top
`timescale 1ns/1ps
`include "tsi_defs.vh"
module tsi_irq_block #(
  parameter BANK_W = 4,
  parameter VEC_W  = 8
) (
  input  wire              i_clk_sys,
  input  wire              i_reset_n,
  input  wire              i_ce_reset,
  input  wire              i_clock_stop,
  input  wire              i_halt,
  input  wire              i_external_irq_pin,
  input  wire              i_timer_req,
  input  wire              i_enable_irq_instr,
  input  wire              i_disable_irq_instr,
  input  wire              i_irq_return_instr,
  input  wire              i_ack_allowed,
  input  wire              i_bank_wr,
  input  wire [BANK_W-1:0] i_bank_wdata,
  input  wire              i_index_enable_wr,
  input  wire              i_index_enable_wdata,
  input  wire [3:0]        i_addr,
  input  wire [3:0]        i_wdata,
  input  wire              i_wr,
  input  wire              i_rd,
  output reg  [3:0]        o_rdata,
  output wire              o_irq_ack,
  output reg  [VEC_W-1:0]  o_vector_ff,
  output reg               o_vector_load_ff,
  output reg  [BANK_W-1:0] o_bank_ff,
  output reg               o_index_enable_flag_ff,
  output wire              o_irq
);
  // Control register bits: [0] pin permit, [1] timer permit, [2] clear pin req, [3] clear timer
  reg        pin_sync1_ff;
  reg        pin_sync2_ff;
  reg        pin_prev_ff;
  reg        pin_request_flag_ff;
  reg        timer_request_flag_ff;
  reg        pin_permit_flag_ff;
  reg        timer_permit_flag_ff;
  reg        global_irq_enable_ff;
  reg        ei_pending_ff;
  reg  [`TSI_EV_W-1:0] status_ff;
  reg  [`TSI_EV_W-1:0] mask_ff;
  reg  [`TSI_EV_W-1:0] nxt_status;
  reg  [3:0] nxt_rdata;
  wire       soft_reset;
  wire       pin_rise;
  wire       ctrl_wr;
  wire       clr_pin_op;
  wire       clr_timer_op;
  wire       clr_busy;
  wire       pin_ready;
  wire       timer_ready;
  wire       ack_pin;
  wire       ack_timer;
  wire [`TSI_BANK_SAVE_W:0] stack_top;
  wire [2:0] stack_level;
  wire       stack_overflow;

  // CE reset and clock stop act like a reset on the enables
  assign soft_reset = i_ce_reset | i_clock_stop;

  // Edge taken between two synchronised samples only
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_sync1_ff <= 1'b0;
      pin_sync2_ff <= 1'b0;
      pin_prev_ff  <= 1'b0;
    end else begin
      pin_sync1_ff <= i_external_irq_pin;
      pin_sync2_ff <= pin_sync1_ff;
      pin_prev_ff  <= pin_sync2_ff;
    end
  end
  // Pin edge is one of exactly two sources
  assign pin_rise = pin_sync2_ff & ~pin_prev_ff;

  assign ctrl_wr      = i_wr & (i_addr == `TSI_REG_CTRL);
  assign clr_pin_op   = ctrl_wr & i_wdata[2];
  assign clr_timer_op = ctrl_wr & i_wdata[3];
  assign clr_busy     = clr_pin_op | clr_timer_op;

  assign pin_ready   = pin_permit_flag_ff & pin_request_flag_ff & global_irq_enable_ff;
  assign timer_ready = timer_permit_flag_ff & timer_request_flag_ff & global_irq_enable_ff;
  // Pin wins; no acknowledge during a request-clear operation
  assign ack_pin   = pin_ready & i_ack_allowed & ~clr_busy;
  assign ack_timer = timer_ready & ~pin_ready & i_ack_allowed & ~clr_busy;
  assign o_irq_ack = ack_pin | ack_timer;

  // Only the peripheral sets; the acknowledge or a software clear write clears
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_request_flag_ff   <= 1'b0;
      timer_request_flag_ff <= 1'b0;
    end else begin
      // Held until acknowledge or software clear; a new edge wins
      if (pin_rise)
        pin_request_flag_ff <= 1'b1;
      else if (ack_pin | clr_pin_op)
        pin_request_flag_ff <= 1'b0;
      if (i_timer_req)
        timer_request_flag_ff <= 1'b1;
      else if (ack_timer | clr_timer_op)
        timer_request_flag_ff <= 1'b0;
    end
  end

  // One write sets any combination of both permit flags
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_permit_flag_ff   <= 1'b0;
      timer_permit_flag_ff <= 1'b0;
    end else if (soft_reset) begin
      // Disabled after CE reset and clock stop
      pin_permit_flag_ff   <= 1'b0;
      timer_permit_flag_ff <= 1'b0;
    end else if (ctrl_wr & ~i_halt) begin
      pin_permit_flag_ff   <= i_wdata[0];
      timer_permit_flag_ff <= i_wdata[1];
    end
    // Halt leaves the permit flags untouched
  end

  // Enable takes effect one cycle later, disable at once
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      global_irq_enable_ff <= 1'b0;
      ei_pending_ff        <= 1'b0;
    end else if (soft_reset | i_disable_irq_instr | o_irq_ack) begin
      global_irq_enable_ff <= 1'b0;
      ei_pending_ff        <= 1'b0;
    end else begin
      ei_pending_ff <= i_enable_irq_instr;
      if (ei_pending_ff)
        global_irq_enable_ff <= 1'b1;
    end
  end

  // Acknowledge hands the vector to the program counter
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_vector_ff      <= {VEC_W{1'b0}};
      o_vector_load_ff <= 1'b0;
    end else begin
      o_vector_load_ff <= o_irq_ack;
      if (ack_pin)
        o_vector_ff <= `TSI_VEC_PIN;
      else if (ack_timer)
        o_vector_ff <= `TSI_VEC_TIMER;
    end
  end

  // Four levels; overflow drops the oldest; bank[1:0] and index enable
  tsi_save_stack #(
    .DEPTH (`TSI_STACK_DEPTH),
    .W     (`TSI_BANK_SAVE_W + 1)
  ) u_nested_save_stack (
    .i_clk_sys  (i_clk_sys),
    .i_reset_n  (i_reset_n),
    .i_push     (o_irq_ack),
    .i_pop      (i_irq_return_instr & ~o_irq_ack),
    .i_data     ({o_index_enable_flag_ff, o_bank_ff[`TSI_BANK_SAVE_W-1:0]}),
    .o_top      (stack_top),
    .o_level    (stack_level),
    .o_overflow (stack_overflow)
  );

  // System register bits: upper bank bits are not saved and stay on return
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bank_ff              <= {BANK_W{1'b0}};
      o_index_enable_flag_ff <= 1'b0;
    end else if (o_irq_ack) begin
      o_bank_ff              <= {BANK_W{1'b0}};
      o_index_enable_flag_ff <= 1'b0;
    end else if (i_irq_return_instr) begin
      o_bank_ff[`TSI_BANK_SAVE_W-1:0] <= stack_top[`TSI_BANK_SAVE_W-1:0];
      o_index_enable_flag_ff          <= stack_top[`TSI_BANK_SAVE_W];
    end else begin
      if (i_bank_wr)
        o_bank_ff <= i_bank_wdata;
      if (i_index_enable_wr)
        o_index_enable_flag_ff <= i_index_enable_wdata;
    end
  end

  // Sticky event status; a new event wins over a write-one clear
  always @* begin
    nxt_status = status_ff;
    if (i_wr & (i_addr == `TSI_REG_STATUS))
      nxt_status = status_ff & ~i_wdata[`TSI_EV_W-1:0];
    nxt_status[`TSI_ST_PIN]      = nxt_status[`TSI_ST_PIN] | ack_pin;
    nxt_status[`TSI_ST_TIMER]    = nxt_status[`TSI_ST_TIMER] | ack_timer;
    nxt_status[`TSI_ST_OVERFLOW] = nxt_status[`TSI_ST_OVERFLOW] | stack_overflow;
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_ff <= {`TSI_EV_W{1'b0}};
      mask_ff   <= {`TSI_EV_W{1'b0}};
    end else begin
      status_ff <= nxt_status;
      if (i_wr & (i_addr == `TSI_REG_MASK))
        mask_ff <= i_wdata[`TSI_EV_W-1:0];
    end
  end

  assign o_irq = |(status_ff & mask_ff);

  // Read data valid the cycle after the strobe, zero otherwise
  always @* begin
    nxt_rdata = 4'h0;
    case (i_addr)
      `TSI_REG_CTRL:   nxt_rdata = {timer_request_flag_ff, pin_request_flag_ff,
                                    timer_permit_flag_ff, pin_permit_flag_ff};
      `TSI_REG_STATUS: nxt_rdata = {1'b0, status_ff};
      `TSI_REG_MASK:   nxt_rdata = {1'b0, mask_ff};
      `TSI_REG_LEVEL:  nxt_rdata = {global_irq_enable_ff, stack_level};
      default:         nxt_rdata = 4'h0;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n)
      o_rdata <= 4'h0;
    else if (i_rd)
      o_rdata <= nxt_rdata;
    else
      o_rdata <= 4'h0;
  end
endmodule

// ### design/tsi_defs.vh
// Constants for the two-source interrupt block
`ifndef TSI_DEFS_VH
`define TSI_DEFS_VH
`define TSI_VEC_PIN      8'h05
`define TSI_VEC_TIMER    8'h03
`define TSI_STACK_DEPTH  4
`define TSI_BANK_SAVE_W  2
`define TSI_REG_CTRL     4'h0
`define TSI_REG_STATUS   4'h1
`define TSI_REG_MASK     4'h2
`define TSI_REG_LEVEL    4'h3
`define TSI_ST_PIN       0
`define TSI_ST_TIMER     1
`define TSI_ST_OVERFLOW  2
`define TSI_EV_W         3
`endif

// ### design/tsi_save_stack.v
// Nested save stack for bank and index-enable bits
`timescale 1ns/1ps
`include "tsi_defs.vh"
module tsi_save_stack #(
  parameter DEPTH = `TSI_STACK_DEPTH,
  parameter W     = `TSI_BANK_SAVE_W + 1
) (
  input  wire         i_clk_sys,
  input  wire         i_reset_n,
  input  wire         i_push,
  input  wire         i_pop,
  input  wire [W-1:0] i_data,
  output reg  [W-1:0] o_top,
  output reg  [2:0]   o_level,
  output wire         o_overflow
);
  reg [W-1:0] entry_ff [0:DEPTH-1];
  reg [2:0]   level_ff;
  integer     k;

  assign o_overflow = i_push & (level_ff == DEPTH);

  always @* begin
    o_top   = entry_ff[0];
    o_level = level_ff;
  end

  // Entry 0 is the newest; a push at full depth shifts the oldest out
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_ff <= 3'h0;
      for (k = 0; k < DEPTH; k = k + 1)
        entry_ff[k] <= {W{1'b0}};
    end else if (i_push) begin
      entry_ff[0] <= i_data;
      for (k = 1; k < DEPTH; k = k + 1)
        entry_ff[k] <= entry_ff[k-1];
      if (level_ff != DEPTH)
        level_ff <= level_ff + 3'h1;
    end else if (i_pop) begin
      for (k = 0; k < DEPTH - 1; k = k + 1)
        entry_ff[k] <= entry_ff[k+1];
      entry_ff[DEPTH-1] <= {W{1'b0}};
      if (level_ff != 3'h0)
        level_ff <= level_ff - 3'h1;
    end
  end
endmodule

// ### dv/tsi_seq_model.sv
// Sequencer model that grants the acknowledge window
`timescale 1ns/1ps
module tsi_seq_model (
  input  wire  i_clk_sys,
  input  wire  i_reset_n,
  input  wire  i_slow,
  output logic o_ack_allowed
);
  logic phase_ff;
  // Slow mode opens the window on alternate cycles only
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) phase_ff <= 1'b0;
    else phase_ff <= ~phase_ff;
  end
  assign o_ack_allowed = ~i_slow | phase_ff;
endmodule

// ### dv/tsi_irq_sva.sv
// Assertion checker for the two-source interrupt block
`timescale 1ns/1ps
module tsi_irq_sva #(
  parameter BANK_W = 4,
  parameter VEC_W  = 8
) (
  input wire              i_clk_sys,
  input wire              i_reset_n,
  input wire              i_ce_reset,
  input wire              i_disable_irq_instr,
  input wire              i_irq_return_instr,
  input wire              i_ack_allowed,
  input wire              i_bank_wr,
  input wire [3:0]        i_addr,
  input wire [3:0]        i_wdata,
  input wire              i_wr,
  input wire              i_rd,
  input wire [3:0]        o_rdata,
  input wire              o_irq_ack,
  input wire [VEC_W-1:0]  o_vector_ff,
  input wire              o_vector_load_ff,
  input wire [BANK_W-1:0] o_bank_ff,
  input wire              o_index_enable_flag_ff
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  property p_load; o_irq_ack |=> o_vector_load_ff; endproperty
  a_load: assert property (p_load) else $error("no vector load after ack");
  property p_vec;
    o_vector_load_ff |-> o_vector_ff == 8'h05 || o_vector_ff == 8'h03;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_clr; o_irq_ack |=> o_bank_ff[1:0] == 2'h0 && !o_index_enable_flag_ff; endproperty
  a_clr: assert property (p_clr) else $error("system bits not cleared");
  property p_allow; o_irq_ack |-> i_ack_allowed; endproperty
  a_allow: assert property (p_allow) else $error("ack outside window");
  property p_rqclr; o_irq_ack |-> !(i_wr && i_addr == 4'h0 && |i_wdata[3:2]); endproperty
  a_rqclr: assert property (p_rqclr) else $error("ack during request clear");
  property p_once; o_irq_ack |=> !o_irq_ack [*2]; endproperty
  a_once: assert property (p_once) else $error("enable not cleared by ack");
  property p_ce; i_ce_reset |=> !o_irq_ack; endproperty
  a_ce: assert property (p_ce) else $error("ack after soft reset");
  property p_rdz; !i_rd |=> o_rdata == 4'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data without read");
  property p_hi;
    i_irq_return_instr && !i_bank_wr && !o_irq_ack |=> $stable(o_bank_ff[BANK_W-1:2]);
  endproperty
  a_hi: assert property (p_hi) else $error("upper bank bits touched");
endmodule
bind tsi_irq_block tsi_irq_sva #(.BANK_W(BANK_W), .VEC_W(VEC_W)) u_sva (.*);

// ### dv/tb.sv
// Testbench for the two-source interrupt block
`timescale 1ns/1ps
module tb;
  logic       clk = 0, rst_n = 0, pin = 0, halt = 0, slow = 0;
  logic       bwr = 0, xwr = 0, xd = 0, wr = 0, rd = 0;
  logic [5:0] pl = 0;
  logic [3:0] bd = 0, addr = 0, wd = 0;
  wire  [3:0] rdata, bank;
  wire  [7:0] vec;
  wire        ack, vld, index_enable_flag, irq, ack_ok;
  int         n_errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  tsi_seq_model tsi_seq_model_i (.i_clk_sys(clk), .i_reset_n(rst_n), .i_slow(slow),
    .o_ack_allowed(ack_ok));
  tsi_irq_block tsi_irq_block_i (.i_clk_sys(clk), .i_reset_n(rst_n), .i_ce_reset(pl[2]),
    .i_clock_stop(pl[5]), .i_halt(halt), .i_external_irq_pin(pin), .i_timer_req(pl[0]),
    .i_enable_irq_instr(pl[4]), .i_disable_irq_instr(pl[3]), .i_irq_return_instr(pl[1]),
    .i_ack_allowed(ack_ok), .i_bank_wr(bwr), .i_bank_wdata(bd), .i_index_enable_wr(xwr),
    .i_index_enable_wdata(xd), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_irq_ack(ack), .o_vector_ff(vec), .o_vector_load_ff(vld),
    .o_bank_ff(bank), .o_index_enable_flag_ff(index_enable_flag), .o_irq(irq));
  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [3:0] exp);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1;
    chk({4'h0, rdata}, {4'h0, exp});
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    pl[b] <= 1;
    @(posedge clk);
    pl[b] <= 0;
  endtask
  // Enable, then wait a bounded time for the vector load
  task automatic ei_ack(input logic [7:0] exp);
    int i;
    pulse(4);
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (vld === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("CHECK FAILED t=%0t no acknowledge", $time);
      report_and_stop;
    end
    chk(vec, exp);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd_reg(4'h0, 4'h0);
    rd_reg(4'h3, 4'h0);
    rd_reg(4'h5, 4'h0);
    for (int k = 0; k < 4; k++) begin
      wr_reg(4'h0, k[3:0]);
      rd_reg(4'h0, k[3:0]);
    end
    pulse(0);
    rd_reg(4'h0, 4'hB);
    wr_reg(4'h0, 4'hB);
    rd_reg(4'h0, 4'h3);
    @(posedge clk);
    bwr <= 1;
    bd <= 4'hF;
    xwr <= 1;
    xd <= 1;
    pin <= 1;
    @(posedge clk);
    bwr <= 0;
    xwr <= 0;
    pulse(0);
    repeat (3) @(posedge clk);
    ei_ack(8'h05);
    chk({bank, 3'h0, index_enable_flag}, 8'h00);
    rd_reg(4'h0, 4'hB);
    ei_ack(8'h03);
    rd_reg(4'h3, 4'h2);
    pulse(1);
    pulse(1);
    #1;
    chk({bank, 3'h0, index_enable_flag}, 8'h31);
    chk({7'h0, irq}, 8'h00);
    wr_reg(4'h2, 4'h3);
    #1;
    chk({7'h0, irq}, 8'h01);
    wr_reg(4'h1, 4'h3);
    #1;
    chk({7'h0, irq}, 8'h00);
    slow <= 1;
    repeat (5) begin
      pulse(0);
      ei_ack(8'h03);
    end
    rd_reg(4'h3, 4'h4);
    rd_reg(4'h1, 4'h6);
    @(posedge clk);
    halt <= 1;
    wr_reg(4'h0, 4'h0);
    rd_reg(4'h0, 4'h3);
    halt <= 0;
    pulse(2);
    rd_reg(4'h0, 4'h0);
    wr_reg(4'h0, 4'h3);
    pulse(5);
    pulse(3);
    rd_reg(4'h0, 4'h0);
    report_and_stop;
  end
endmodule
